// ### logic/secdec_pkg.sv
package secdec_pkg;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OP_WR_PW     = 8'hF1;
	localparam logic [7:0] OP_RD_PW     = 8'hF2;
	localparam logic [7:0] OP_UNLOCK    = 8'hBC;
	localparam logic [7:0] OP_WR_KEY    = 8'hF3;
	localparam logic [7:0] OP_RD_KEY    = 8'hF4;
	localparam logic [7:0] OP_WR_FEAT   = 8'hE4;
	localparam logic [7:0] OP_RD_FEAT   = 8'hE7;
	localparam logic [7:0] OP_WR_FBITS  = 8'hF8;
	localparam logic [7:0] OP_RD_FBITS  = 8'hFB;
	localparam logic [7:0] OP_WR_OTP    = 8'hF9;
	localparam logic [7:0] OP_RD_OTP    = 8'hFA;
	localparam logic [7:0] OP_WR_PUBK   = 8'h59;
	localparam logic [7:0] OP_RD_PUBK   = 8'h5A;
	localparam logic [7:0] OP_ALT_BOOT  = 8'h7F;
	localparam logic [7:0] OP_RD_DRYRUN = 8'h5D;

	// ****************************************
	// Phase lengths in bytes
	// ****************************************
	localparam logic [6:0] LEN_OPERAND = 7'h03;
	localparam logic [6:0] LEN_PW      = 7'h10;
	localparam logic [6:0] LEN_UNLOCK  = 7'h08;
	localparam logic [6:0] LEN_KEY     = 7'h20;
	localparam logic [6:0] LEN_FEAT    = 7'h0C;
	localparam logic [6:0] LEN_FBITS   = 7'h02;
	localparam logic [6:0] LEN_OTP     = 7'h04;
	localparam logic [6:0] LEN_PUBK    = 7'h40;
	localparam logic [6:0] LEN_BOOT    = 7'h04;
	localparam logic [6:0] LEN_DRYRUN  = 7'h04;

	// ****************************************
	// Fuse map and field positions
	// ****************************************
	localparam int         GROUP_BITS = 2;
	localparam int         FEAT_BYTES = 48;
	localparam logic [7:0] PW_BASE    = 8'h00;
	localparam logic [7:0] KEY_BASE   = 8'h10;
	localparam logic [7:0] FBITS_BASE = 8'h30;
	localparam logic [7:0] OTP_BASE   = 8'h32;
	localparam logic [7:0] PUBK_BASE  = 8'h42;
	localparam int         FUSE_BYTES = 130;
	localparam int         FBIT_PW_ACTIVE  = 15;
	localparam int         FBIT_KEY_ACTIVE = 14;
	localparam int         FEAT_DECRYPT_BIT = 0;
	localparam int         BUSY_BIT   = 0;
	localparam logic [7:0] BOOT_RESET = 8'h00;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS    = 10;
	localparam int FUSE_PROG_NS     = 10000;
	localparam int FUSE_PROG_CYCLES = (FUSE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPERAND,
		ST_DATA_IN,
		ST_DATA_OUT,
		ST_APPLY,
		ST_PROGRAM
	} state_t;

endpackage : secdec_pkg

// ### logic/prog_timer.sv
module prog_timer #(
	parameter int unsigned CYCLES = 1000
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic srst,
	// Control
	input  wire logic start,
	output logic      done_q
);
	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] cnt_q;
	logic         run_q;

	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				cnt_q <= W'(CYCLES - 1);
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q == '0) begin
					run_q  <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end

endmodule : prog_timer

// ### logic/fuse_bank.sv
module fuse_bank #(
	parameter int         DEPTH       = 130,
	parameter logic [7:0] STATUS_ADDR = 8'h30
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// Program port
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_addr,
	input  wire logic [7:0]  wr_data,
	// Read ports
	input  wire logic [7:0]  rd_addr,
	output logic      [7:0]  rd_data,
	output logic      [15:0] status_word
);
	// Fuses keep their content through reset; blank fuses read as zero
	logic [7:0] mem [0:DEPTH-1] = '{default: 8'h00};
	logic [7:0] cur_byte;

	assign cur_byte    = mem[wr_addr];
	assign rd_data     = (int'(rd_addr) < DEPTH) ? mem[rd_addr] : 8'h00;
	assign status_word = {mem[STATUS_ADDR], mem[STATUS_ADDR + 8'h01]};

	always_ff @(posedge clock) begin
		if (wr_en && int'(wr_addr) < DEPTH) begin
			mem[wr_addr] <= mem[wr_addr] | wr_data;
		end
	end

	a_fuse_no_revert: assert property (@(posedge clock) disable iff (srst)
		wr_en |=> ((mem[$past(wr_addr)] & $past(cur_byte)) == $past(cur_byte)))
		else $error("programmed fuse bit reverted");

endmodule : fuse_bank

// ### logic/security_command_decoder.sv
module security_command_decoder #(
	parameter logic [7:0]  POLL_BUSY_OPCODE = 8'hF0,
	parameter int unsigned PROG_CYCLES      = secdec_pkg::FUSE_PROG_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// Command byte stream
	input  wire logic        byte_valid,
	input  wire logic        byte_first,
	input  wire logic [7:0]  byte_data,
	// Read data
	input  wire logic        rd_req,
	output logic             rd_valid_q,
	output logic      [7:0]  rd_data_q,
	// Status
	output logic             busy_q,
	output logic             cmd_error_q,
	output logic             reconfig_unlocked_q,
	output logic             decrypt_enable_q,
	// Boot address and signature
	input  wire logic [31:0] dryrun_signature,
	output logic             alt_boot_override_q,
	output logic      [31:0] alt_boot_addr_q
);

	// ****************************************
	// Opcode decode
	// ****************************************
	function automatic logic [6:0] op_len(input logic [7:0] op);
		case (op)
			secdec_pkg::OP_WR_PW, secdec_pkg::OP_RD_PW:       op_len = secdec_pkg::LEN_PW;
			secdec_pkg::OP_UNLOCK:                            op_len = secdec_pkg::LEN_UNLOCK;
			secdec_pkg::OP_WR_KEY, secdec_pkg::OP_RD_KEY:     op_len = secdec_pkg::LEN_KEY;
			secdec_pkg::OP_WR_FEAT, secdec_pkg::OP_RD_FEAT:   op_len = secdec_pkg::LEN_FEAT;
			secdec_pkg::OP_WR_FBITS, secdec_pkg::OP_RD_FBITS: op_len = secdec_pkg::LEN_FBITS;
			secdec_pkg::OP_WR_OTP, secdec_pkg::OP_RD_OTP:     op_len = secdec_pkg::LEN_OTP;
			secdec_pkg::OP_WR_PUBK, secdec_pkg::OP_RD_PUBK:   op_len = secdec_pkg::LEN_PUBK;
			secdec_pkg::OP_ALT_BOOT:                          op_len = secdec_pkg::LEN_BOOT;
			secdec_pkg::OP_RD_DRYRUN:                         op_len = secdec_pkg::LEN_DRYRUN;
			default:                                          op_len = 7'h00;
		endcase
	endfunction : op_len

	function automatic logic op_is_write(input logic [7:0] op);
		case (op)
			secdec_pkg::OP_WR_PW, secdec_pkg::OP_UNLOCK, secdec_pkg::OP_WR_KEY,
			secdec_pkg::OP_WR_FEAT, secdec_pkg::OP_WR_FBITS, secdec_pkg::OP_WR_OTP,
			secdec_pkg::OP_WR_PUBK, secdec_pkg::OP_ALT_BOOT: op_is_write = 1'b1;
			default:                                         op_is_write = 1'b0;
		endcase
	endfunction : op_is_write

	function automatic logic op_is_fuse(input logic [7:0] op);
		case (op)
			secdec_pkg::OP_WR_PW, secdec_pkg::OP_WR_KEY, secdec_pkg::OP_WR_FBITS,
			secdec_pkg::OP_WR_OTP, secdec_pkg::OP_WR_PUBK: op_is_fuse = 1'b1;
			default:                                       op_is_fuse = 1'b0;
		endcase
	endfunction : op_is_fuse

	// ****************************************
	// State
	// ****************************************
	secdec_pkg::state_t state_q;
	logic [7:0]         op_q;
	logic [23:0]        operand_q;
	logic [6:0]         len_q;
	logic [6:0]         cnt_q;
	logic [7:0]         stage_q [0:63];
	logic [7:0]         feat_q  [0:secdec_pkg::FEAT_BYTES-1];
	logic               mismatch_q;
	logic               prog_start_q;

	logic                          prog_done;
	logic [7:0]                    fuse_base;
	logic [7:0]                    fuse_addr;
	logic [7:0]                    fuse_rd_data;
	logic [15:0]                   fbits;
	logic                          fuse_we;
	logic                          pw_active;
	logic                          key_active;
	logic [secdec_pkg::GROUP_BITS-1:0] grp;
	logic [5:0]                    feat_idx;
	logic [7:0]                    rd_byte;
	logic [31:0]                   boot_word;
	logic                          start_cmd;
	logic                          poll_cmd;
	logic                          data_byte;
	logic                          last_byte;

	assign grp        = operand_q[secdec_pkg::GROUP_BITS-1:0];
	assign feat_idx   = 6'(int'(grp) * int'(secdec_pkg::LEN_FEAT) + int'(cnt_q));
	assign pw_active  = fbits[secdec_pkg::FBIT_PW_ACTIVE];
	assign key_active = fbits[secdec_pkg::FBIT_KEY_ACTIVE];
	assign boot_word  = {stage_q[0], stage_q[1], stage_q[2], stage_q[3]};
	assign poll_cmd   = byte_valid && byte_first && byte_data == POLL_BUSY_OPCODE;
	assign start_cmd  = byte_valid && byte_first && !poll_cmd && state_q != secdec_pkg::ST_PROGRAM
		&& state_q != secdec_pkg::ST_APPLY;
	assign data_byte  = byte_valid && !byte_first;
	assign last_byte  = cnt_q == len_q - 7'h01;
	assign fuse_we    = state_q == secdec_pkg::ST_PROGRAM && prog_done;
	assign fuse_addr  = fuse_base + {1'b0, cnt_q};

	// ****************************************
	// Fuse address per command
	// ****************************************
	always_comb begin
		case (op_q)
			secdec_pkg::OP_WR_PW, secdec_pkg::OP_RD_PW,
			secdec_pkg::OP_UNLOCK:                            fuse_base = secdec_pkg::PW_BASE;
			secdec_pkg::OP_WR_KEY, secdec_pkg::OP_RD_KEY:     fuse_base = secdec_pkg::KEY_BASE;
			secdec_pkg::OP_WR_FBITS, secdec_pkg::OP_RD_FBITS: fuse_base = secdec_pkg::FBITS_BASE;
			secdec_pkg::OP_WR_OTP, secdec_pkg::OP_RD_OTP:
				fuse_base = secdec_pkg::OTP_BASE + 8'({grp, 2'b00});
			secdec_pkg::OP_WR_PUBK, secdec_pkg::OP_RD_PUBK:   fuse_base = secdec_pkg::PUBK_BASE;
			default:                                          fuse_base = 8'h00;
		endcase
	end

	// ****************************************
	// Read data source
	// ****************************************
	always_comb begin
		case (op_q)
			secdec_pkg::OP_RD_PW:    rd_byte = pw_active ? 8'h00 : fuse_rd_data;
			secdec_pkg::OP_RD_KEY:   rd_byte = key_active ? 8'h00 : fuse_rd_data;
			secdec_pkg::OP_RD_FBITS: rd_byte = fuse_rd_data;
			secdec_pkg::OP_RD_OTP:   rd_byte = fuse_rd_data;
			secdec_pkg::OP_RD_PUBK:  rd_byte = fuse_rd_data;
			secdec_pkg::OP_RD_FEAT:  rd_byte = feat_q[feat_idx];
			secdec_pkg::OP_RD_DRYRUN: begin
				case (cnt_q[1:0])
					2'h0:    rd_byte = dryrun_signature[31:24];
					2'h1:    rd_byte = dryrun_signature[23:16];
					2'h2:    rd_byte = dryrun_signature[15:8];
					default: rd_byte = dryrun_signature[7:0];
				endcase
			end
			default:                 rd_byte = 8'h00;
		endcase
	end

	// ****************************************
	// Command sequencer
	// ****************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			state_q   <= secdec_pkg::ST_IDLE;
			op_q      <= 8'h00;
			operand_q <= 24'h000000;
			len_q     <= 7'h00;
			cnt_q     <= 7'h00;
		end else begin
			case (state_q)
				secdec_pkg::ST_IDLE, secdec_pkg::ST_OPERAND,
				secdec_pkg::ST_DATA_IN, secdec_pkg::ST_DATA_OUT: begin
					if (start_cmd) begin
						// A new opcode abandons a command still in its operand or data phase
						op_q    <= byte_data;
						len_q   <= op_len(byte_data);
						cnt_q   <= 7'h00;
						state_q <= (op_len(byte_data) != 7'h00) ? secdec_pkg::ST_OPERAND
							: secdec_pkg::ST_IDLE;
					end else if (state_q == secdec_pkg::ST_OPERAND && data_byte) begin
						operand_q <= {operand_q[15:0], byte_data};
						if (cnt_q == secdec_pkg::LEN_OPERAND - 7'h01) begin
							cnt_q   <= 7'h00;
							state_q <= op_is_write(op_q) ? secdec_pkg::ST_DATA_IN
								: secdec_pkg::ST_DATA_OUT;
						end else begin
							cnt_q <= cnt_q + 7'h01;
						end
					end else if (state_q == secdec_pkg::ST_DATA_IN && data_byte) begin
						cnt_q <= last_byte ? 7'h00 : cnt_q + 7'h01;
						if (last_byte) begin
							state_q <= secdec_pkg::ST_APPLY;
						end
					end else if (state_q == secdec_pkg::ST_DATA_OUT && rd_req) begin
						cnt_q <= last_byte ? 7'h00 : cnt_q + 7'h01;
						if (last_byte) begin
							state_q <= secdec_pkg::ST_IDLE;
						end
					end
				end
				secdec_pkg::ST_APPLY: begin
					cnt_q   <= 7'h00;
					state_q <= op_is_fuse(op_q) ? secdec_pkg::ST_PROGRAM : secdec_pkg::ST_IDLE;
				end
				secdec_pkg::ST_PROGRAM: begin
					if (prog_done) begin
						cnt_q <= last_byte ? 7'h00 : cnt_q + 7'h01;
						if (last_byte) begin
							state_q <= secdec_pkg::ST_IDLE;
						end
					end
				end
				default: state_q <= secdec_pkg::ST_IDLE;
			endcase
		end
	end

	// Data phase bytes are staged so the slow fuse writes need no back-pressure
	always_ff @(posedge clock) begin
		if (state_q == secdec_pkg::ST_DATA_IN && data_byte && !start_cmd) begin
			stage_q[cnt_q[5:0]] <= byte_data;
		end
	end

	// ****************************************
	// Fuse programming and busy
	// ****************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			prog_start_q <= 1'b0;
			busy_q       <= 1'b0;
		end else begin
			prog_start_q <= (state_q == secdec_pkg::ST_APPLY && op_is_fuse(op_q))
				|| (fuse_we && !last_byte);
			if (state_q == secdec_pkg::ST_DATA_IN && data_byte && !start_cmd && last_byte
				&& op_is_fuse(op_q)) begin
				busy_q <= 1'b1;
			end else if (fuse_we && last_byte) begin
				busy_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Unlock, features and boot address
	// ****************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			mismatch_q          <= 1'b0;
			reconfig_unlocked_q <= 1'b0;
		end else if (state_q == secdec_pkg::ST_OPERAND && op_q == secdec_pkg::OP_UNLOCK) begin
			mismatch_q <= 1'b0;
		end else if (state_q == secdec_pkg::ST_DATA_IN && op_q == secdec_pkg::OP_UNLOCK
			&& data_byte && byte_data != fuse_rd_data) begin
			mismatch_q <= 1'b1;
		end else if (state_q == secdec_pkg::ST_APPLY && op_q == secdec_pkg::OP_UNLOCK) begin
			reconfig_unlocked_q <= !mismatch_q;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < secdec_pkg::FEAT_BYTES; i++) begin
				feat_q[i] <= 8'h00;
			end
			decrypt_enable_q <= 1'b0;
		end else begin
			if (state_q == secdec_pkg::ST_APPLY && op_q == secdec_pkg::OP_WR_FEAT) begin
				for (int i = 0; i < int'(secdec_pkg::LEN_FEAT); i++) begin
					feat_q[6'(int'(grp) * int'(secdec_pkg::LEN_FEAT) + i)] <= stage_q[i];
				end
			end
			decrypt_enable_q <= feat_q[0][secdec_pkg::FEAT_DECRYPT_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			alt_boot_override_q <= 1'b0;
			alt_boot_addr_q     <= {4{secdec_pkg::BOOT_RESET}};
		end else if (state_q == secdec_pkg::ST_APPLY && op_q == secdec_pkg::OP_ALT_BOOT) begin
			alt_boot_override_q <= 1'b1;
			alt_boot_addr_q     <= boot_word;
		end
	end

	// ****************************************
	// Read answers, busy poll and errors
	// ****************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= 8'h00;
		end else if (poll_cmd) begin
			rd_valid_q <= 1'b1;
			rd_data_q  <= 8'(busy_q) << secdec_pkg::BUSY_BIT;
		end else if (state_q == secdec_pkg::ST_DATA_OUT && rd_req && !start_cmd) begin
			rd_valid_q <= 1'b1;
			rd_data_q  <= rd_byte;
		end else begin
			rd_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cmd_error_q <= 1'b0;
		end else if (byte_valid && byte_first && !poll_cmd
			&& (!start_cmd || op_len(byte_data) == 7'h00)) begin
			cmd_error_q <= 1'b1;
		end else if (start_cmd) begin
			cmd_error_q <= 1'b0;
		end
	end

	// ****************************************
	// Submodules
	// ****************************************
	prog_timer #(
		.CYCLES (PROG_CYCLES)
	) u_timer (
		.clock  (clock),
		.srst   (srst),
		.start  (prog_start_q),
		.done_q (prog_done)
	);

	fuse_bank #(
		.DEPTH       (secdec_pkg::FUSE_BYTES),
		.STATUS_ADDR (secdec_pkg::FBITS_BASE)
	) u_fuses (
		.clock       (clock),
		.srst        (srst),
		.wr_en       (fuse_we),
		.wr_addr     (fuse_addr),
		.wr_data     (stage_q[cnt_q[5:0]]),
		.rd_addr     (fuse_addr),
		.rd_data     (fuse_rd_data),
		.status_word (fbits)
	);

	// ****************************************
	// Checks
	// ****************************************
	a_busy_in_prog: assert property (@(posedge clock) disable iff (srst)
		state_q == secdec_pkg::ST_PROGRAM |-> busy_q)
		else $error("busy low during fuse programming");

	a_fuse_under_prog: assert property (@(posedge clock) disable iff (srst)
		fuse_we |-> busy_q && op_is_fuse(op_q))
		else $error("fuse written outside a program command");

	a_pw_read_block: assert property (@(posedge clock) disable iff (srst)
		state_q == secdec_pkg::ST_DATA_OUT && op_q == secdec_pkg::OP_RD_PW && rd_req
		&& !start_cmd && !poll_cmd && pw_active |=> rd_valid_q && rd_data_q == 8'h00)
		else $error("password readable while protected");

	a_unlock_len: assert property (@(posedge clock) disable iff (srst)
		state_q == secdec_pkg::ST_DATA_IN && op_q == secdec_pkg::OP_UNLOCK |-> len_q == 7'h08)
		else $error("unlock data phase not eight bytes");

	a_key_read_len: assert property (@(posedge clock) disable iff (srst)
		state_q == secdec_pkg::ST_DATA_OUT && op_q == secdec_pkg::OP_RD_KEY |-> len_q == 7'h20)
		else $error("key read not thirty-two bytes");

	a_boot_take: assert property (@(posedge clock) disable iff (srst)
		state_q == secdec_pkg::ST_APPLY && op_q == secdec_pkg::OP_ALT_BOOT
		|=> alt_boot_override_q && alt_boot_addr_q == $past(boot_word))
		else $error("boot address not taken");

	a_dryrun_first: assert property (@(posedge clock) disable iff (srst)
		state_q == secdec_pkg::ST_DATA_OUT && op_q == secdec_pkg::OP_RD_DRYRUN && rd_req
		&& cnt_q == 7'h00 && !start_cmd && !poll_cmd
		|=> rd_valid_q && rd_data_q == $past(dryrun_signature[31:24]))
		else $error("dry-run signature byte wrong");

	a_poll_answer: assert property (@(posedge clock) disable iff (srst)
		poll_cmd |=> rd_valid_q && rd_data_q[secdec_pkg::BUSY_BIT] == $past(busy_q))
		else $error("busy poll answer wrong");

	a_busy_rise: assert property (@(posedge clock) disable iff (srst)
		state_q == secdec_pkg::ST_APPLY && op_is_fuse(op_q)
		|-> busy_q ##1 (busy_q && state_q == secdec_pkg::ST_PROGRAM)[*2])
		else $error("busy not held after program data");

endmodule : security_command_decoder

// ### test/cmd_host.sv
module cmd_host #(
	parameter logic [7:0] POLL_OP = 8'hF0
) (
	// Clock
	input  wire logic       clock,
	// Command stream
	output logic            byte_valid,
	output logic            byte_first,
	output logic      [7:0] byte_data,
	output logic            rd_req,
	// Answers
	input  wire logic       rd_valid_q,
	input  wire logic [7:0] rd_data_q
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		byte_valid = 1'b0;
		byte_first = 1'b0;
		byte_data  = 8'h00;
		rd_req     = 1'b0;
	end

	// One byte, held over exactly one sampling edge
	task automatic put(input logic first, input logic [7:0] d);
		@(posedge clock);
		byte_valid <= 1'b1;
		byte_first <= first;
		byte_data  <= d;
		@(posedge clock);
		byte_valid <= 1'b0;
		byte_first <= 1'b0;
		// Released bus must not keep showing the old byte
		byte_data  <= ~d;
	endtask : put

	// Opcode, then three operands; group select in the last
	task automatic cmd(input logic [7:0] op, input logic [7:0] sel);
		put(1'b1, op);
		put(1'b0, 8'h00);
		put(1'b0, 8'h00);
		put(1'b0, sel);
	endtask : cmd

	// Answer is expected exactly one cycle later; X when it is missing
	task automatic get(output logic [7:0] d);
		@(posedge clock);
		rd_req <= 1'b1;
		@(posedge clock);
		rd_req <= 1'b0;
		#1;
		d = (rd_valid_q === 1'b1) ? rd_data_q : 8'hXX;
	endtask : get

	task automatic poll(output logic [7:0] d);
		put(1'b1, POLL_OP);
		#1;
		d = (rd_valid_q === 1'b1) ? rd_data_q : 8'hXX;
	endtask : poll
endmodule : cmd_host

// ### test/security_command_decoder_tb_top.sv
`define CHK(n, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("[ERR] %s exp %0h got %0h", n, e, g); \
	end \
end

module security_command_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Short fuse time keeps the run small
	localparam int unsigned C = 4;
	logic        clock;
	logic        srst;
	logic        byte_valid;
	logic        byte_first;
	logic [7:0]  byte_data;
	logic        rd_req;
	logic        rd_valid_q;
	logic [7:0]  rd_data_q;
	logic        busy_q;
	logic        cmd_error_q;
	logic        unlocked;
	logic        decrypt;
	logic [31:0] sig;
	logic        boot_ovr;
	logic [31:0] boot_addr;
	int          failures;
	int          cmp_count;

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	cmd_host host (.clock(clock), .byte_valid(byte_valid), .byte_first(byte_first),
		.byte_data(byte_data), .rd_req(rd_req), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q));

	security_command_decoder #(.POLL_BUSY_OPCODE(8'hF0), .PROG_CYCLES(C)) uut (.clock(clock),
		.srst(srst), .byte_valid(byte_valid), .byte_first(byte_first), .byte_data(byte_data),
		.rd_req(rd_req), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .busy_q(busy_q),
		.cmd_error_q(cmd_error_q), .reconfig_unlocked_q(unlocked), .decrypt_enable_q(decrypt),
		.dryrun_signature(sig), .alt_boot_override_q(boot_ovr), .alt_boot_addr_q(boot_addr));

	function automatic logic [7:0] pat(input logic [7:0] s, input int i);
		return s + 8'(i) * 8'h13;
	endfunction : pat

	task automatic wait_idle;
		logic [7:0] d;
		for (int k = 0; k < 400; k++) begin
			host.poll(d);
			if (d[0] === 1'b0)
				break;
		end
		`CHK("busy_q", 1'b0, busy_q)
	endtask : wait_idle

	task automatic wr(input logic [7:0] op, sel, s, input int n, input bit prog);
		logic [7:0] d;
		host.cmd(op, sel);
		for (int i = 0; i < n; i++)
			host.put(1'b0, pat(s, i));
		if (prog) begin
			host.poll(d);
			`CHK("busy poll", 8'h01, d)
			wait_idle();
		end
		else
			repeat (3) @(posedge clock);
	endtask : wr

	task automatic rd(input logic [7:0] op, sel, s, input int n, input bit blank);
		logic [7:0] d;
		host.cmd(op, sel);
		for (int i = 0; i < n; i++) begin
			host.get(d);
			`CHK("read byte", blank ? 8'h00 : pat(s, i), d)
		end
		$display("read of %h done", op);
	endtask : rd

	task automatic t_fuses;
		logic [7:0] wo [4] = '{8'hF1, 8'hF3, 8'hF9, 8'h59};
		logic [7:0] ro [4] = '{8'hF2, 8'hF4, 8'hFA, 8'h5A};
		int         nl [4] = '{16, 32, 4, 64};
		for (int k = 0; k < 4; k++) begin
			wr(wo[k], 8'h02, 8'(k * 32), nl[k], 1'b1);
			rd(ro[k], 8'h02, 8'(k * 32), nl[k], 1'b0);
		end
		rd(8'hFA, 8'h01, 8'h00, 4, 1'b1);
	endtask : t_fuses

	task automatic t_misc;
		logic [7:0] d;
		wr(8'hF8, 8'h00, 8'h01, 2, 1'b1);
		rd(8'hFB, 8'h00, 8'h01, 2, 1'b0);
		wr(8'hF8, 8'h00, 8'h02, 2, 1'b1);
		t_fuses();
		wr(8'hE4, 8'h00, 8'h01, 12, 1'b0);
		`CHK("decrypt", 1'b1, decrypt)
		wr(8'hE4, 8'h03, 8'h30, 12, 1'b0);
		rd(8'hE7, 8'h03, 8'h30, 12, 1'b0);
		rd(8'hE7, 8'h00, 8'h01, 12, 1'b0);
		wr(8'h7F, 8'h00, 8'h12, 4, 1'b0);
		`CHK("boot addr", 32'h1225384B, boot_addr)
		`CHK("boot ovr", 1'b1, boot_ovr)
		sig <= 32'hA5C30F96;
		host.cmd(8'h5D, 8'h00);
		for (int i = 0; i < 4; i++) begin
			host.get(d);
			`CHK("signature", 8'(32'hA5C30F96 >> (24 - 8 * i)), d)
		end
		wr(8'hBC, 8'h00, 8'h00, 8, 1'b0);
		`CHK("unlocked", 1'b1, unlocked)
		wr(8'hBC, 8'h00, 8'h01, 8, 1'b0);
		`CHK("unlocked", 1'b0, unlocked)
		$display("misc test done");
	endtask : t_misc

	task automatic t_protect;
		logic [7:0] d;
		host.put(1'b1, 8'h00);
		@(posedge clock);
		`CHK("unknown op", 1'b1, cmd_error_q)
		host.cmd(8'hF8, 8'h00);
		host.put(1'b0, 8'h80);
		host.put(1'b0, 8'h00);
		host.put(1'b1, 8'hF2);
		@(posedge clock);
		`CHK("refused op", 1'b1, cmd_error_q)
		`CHK("busy", 1'b1, busy_q)
		wait_idle();
		rd(8'hF2, 8'h00, 8'h00, 16, 1'b1);
		`CHK("error clr", 1'b0, cmd_error_q)
		host.cmd(8'hFB, 8'h00);
		host.get(d);
		`CHK("fbits0", 8'h83, d)
		host.get(d);
		`CHK("fbits1", 8'h15, d)
		$display("protect test done");
	endtask : t_protect

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		failures = 0;
		cmp_count = 0;
		srst = 1'b1;
		sig = 32'h0000_0000;
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1;
		`CHK("reset busy", 1'b0, busy_q)
		`CHK("reset ovr", 1'b0, boot_ovr)
		t_misc();
		t_protect();
		end_of_test();
	end

	initial begin
		#300us;
		failures++;
		$display("[ERR] watchdog expired");
		end_of_test();
	end
endmodule : security_command_decoder_tb_top
